/* File: nvclock_pkg.sv */
// Shared constants for the nonvolatile memory with calendar clock.
// Assumes a single 25 MHz clock and a synchronous, active-high reset.
package nvclock_pkg;
   localparam int          ADDR_W         = 19;
   localparam int          DATA_W         = 8;
   localparam int          MEM_WORDS      = 524288;
   localparam int          CLK_HZ         = 25000000;
   localparam int          SEC_PERIOD_S   = 1;
   localparam int          SEC_CYCLES     = CLK_HZ * SEC_PERIOD_S;
   localparam int          FT_HZ          = 512;
   localparam int          FT_HALF_CYCLES = CLK_HZ / (2 * FT_HZ);
   // Clock register index, taken from the three low address bits.
   localparam logic [2:0]  IDX_CENT       = 3'h0;
   localparam logic [2:0]  IDX_SEC        = 3'h1;
   localparam logic [2:0]  IDX_MIN        = 3'h2;
   localparam logic [2:0]  IDX_HOUR       = 3'h3;
   localparam logic [2:0]  IDX_DAY        = 3'h4;
   localparam logic [2:0]  IDX_DATE       = 3'h5;
   localparam logic [2:0]  IDX_MONTH      = 3'h6;
   localparam logic [2:0]  IDX_YEAR       = 3'h7;
   localparam logic [15:0] CLK_PAGE       = 16'hFFFF;
   // Field positions.
   localparam int          CTRL_W_BIT     = 7;
   localparam int          CTRL_R_BIT     = 6;
   localparam int          SEC_OSC_BIT    = 7;
   localparam int          DAY_BF_BIT     = 7;
   localparam int          DAY_FT_BIT     = 6;
   // Limits in BCD.
   localparam logic [7:0]  BCD_59         = 8'h59;
   localparam logic [7:0]  BCD_23         = 8'h23;
   localparam logic [7:0]  BCD_12         = 8'h12;
   localparam logic [7:0]  BCD_99         = 8'h99;
   localparam logic [7:0]  BCD_01         = 8'h01;
   localparam logic [7:0]  BCD_07         = 8'h07;
   localparam logic [7:0]  BCD_02         = 8'h02;
   // Reset values of the time count: 2000-01-01, day 1, 00:00:00.
   localparam logic [7:0]  RST_CENT       = 8'h20;
   localparam logic [7:0]  RST_ONE        = 8'h01;
   // Avalon word indices of the housekeeping registers.
   localparam logic [1:0]  AV_STATUS      = 2'h0;
   localparam logic [1:0]  AV_MASK        = 2'h1;
   localparam logic [1:0]  AV_POWER       = 2'h2;
   localparam int          EV_SEC         = 0;
   localparam int          EV_PFAIL       = 1;
   localparam int          EV_LOAD        = 2;
   localparam int          EV_W           = 3;
endpackage

/* File: nv_mem_array.sv */
// Byte-wide static memory array with registered read data.
// Assumes writes and reads are qualified by the caller.
module nv_mem_array (
   input  wire logic                              mclk,
   input  wire logic                              wr_en,
   input  wire logic [nvclock_pkg::ADDR_W-1:0]    addr,
   input  wire logic [nvclock_pkg::DATA_W-1:0]    wdata,
   output      logic [nvclock_pkg::DATA_W-1:0]    rdata
);
   logic [nvclock_pkg::DATA_W-1:0] mem_reg [0:nvclock_pkg::MEM_WORDS-1];

   // The array has no reset, as a battery-backed memory keeps its contents.
   always_ff @(posedge mclk) begin
      if (wr_en) begin
         mem_reg[addr] <= wdata;
      end
      rdata <= mem_reg[addr];
   end
endmodule

/* File: nv_sram_calendar_clock.sv */
// Nonvolatile byte memory with a double-buffered BCD calendar clock.
// Assumes the host pins are synchronous to mclk and an Avalon-MM master for housekeeping.
// Overview of operation
// - Memory of 512k bytes behind one byte-wide address and data port.
// - Clock registers sit at the top eight addresses, accessed like memory.
// - BCD century, year, month, date, day, hours, minutes, seconds; 24-hour hours.
// - Month lengths and leap years corrected automatically, right through 2100.
// - A separate century byte gives the full four-digit year.
// - Visible registers are buffered; the internal count keeps running during access.
// - With supply out of tolerance, all host reads and writes are ignored.
// - A readable flag shows whether the backup battery is adequate.
// - Active-low reset output held low while supply is not valid.
// - Write bit freezes registers; writing 00h loads them into the count.
// - Read bit freezes registers; writing 00h resumes, century left unchanged.
// - Seconds bit 7 set stops the oscillator; cleared lets it run.
// - Frequency-test bit makes seconds LSB toggle at 512 Hz while running.
module nv_sram_calendar_clock #(
   parameter int SEC_CYCLES     = nvclock_pkg::SEC_CYCLES,
   parameter int FT_HALF_CYCLES = nvclock_pkg::FT_HALF_CYCLES
) (
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic [18:0] address_pins,
   input  wire logic [7:0]  data_lines_in,
   output      logic [7:0]  data_lines_out,
   output      logic        data_lines_oe,
   input  wire logic        chip_en_n,
   input  wire logic        out_en_n,
   input  wire logic        write_en_n,
   input  wire logic        supply_ok,
   input  wire logic        battery_ok,
   output      logic        por_out_n,
   input  wire logic [1:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output      logic [31:0] avs_readdata,
   output      logic        avs_waitrequest,
   output      logic        irq
);
   logic [7:0]  cnt_reg [0:7];
   logic [7:0]  cnt_next [0:7];
   logic [7:0]  vis_reg [0:7];
   logic        w_bit_reg;
   logic        r_bit_reg;
   logic        crystal_halt_bit;
   logic        freq_test_bit;
   logic        ft_phase_reg;
   logic [24:0] div_reg;
   logic [15:0] ft_div_reg;
   logic        sel_clk_reg;
   logic [7:0]  clk_rd_reg;
   logic [7:0]  mem_rdata;
   logic        oe_reg;
   logic        supply_prev_reg;
   logic        por_reg;
   logic [3:0]  status_reg;
   logic [3:0]  mask_reg;
   logic        ack_reg;
   logic [31:0] rdata_reg;
   logic [3:0]  events;
   logic [7:0]  rd_mux;

   // Host pin decode.
   wire         host_acc   = supply_ok & ~chip_en_n;
   wire         host_wr    = host_acc & ~write_en_n;
   wire         host_rd    = host_acc & write_en_n & ~out_en_n;
   wire         clk_sel    = (address_pins[18:3] == nvclock_pkg::CLK_PAGE);
   wire  [2:0]  idx        = address_pins[2:0];
   wire         clk_wr     = host_wr & clk_sel;
   wire         mem_wr     = host_wr & ~clk_sel;
   wire         ctrl_wr    = clk_wr & (idx == nvclock_pkg::IDX_CENT);
   wire         wr_w       = data_lines_in[nvclock_pkg::CTRL_W_BIT];
   wire         wr_r       = data_lines_in[nvclock_pkg::CTRL_R_BIT];
   wire         wr_clear   = ctrl_wr & ~wr_w & ~wr_r;
   wire         load_time  = wr_clear & w_bit_reg;
   wire         cent_plain = wr_clear & ~w_bit_reg & ~r_bit_reg;
   wire         halted     = w_bit_reg | r_bit_reg;
   wire         sec_tick   = ~crystal_halt_bit & (div_reg == 25'(SEC_CYCLES - 1));
   wire         ft_tick    = ~crystal_halt_bit & (ft_div_reg == 16'(FT_HALF_CYCLES - 1));
   wire         run_tick   = sec_tick & ~load_time;

   // Avalon decode.
   wire         av_req     = avs_read | avs_write;
   wire         av_take    = av_req & ack_reg;
   wire         av_wr      = avs_write & av_take;
   wire         wr_status  = av_wr & (avs_address == nvclock_pkg::AV_STATUS);
   wire         wr_mask    = av_wr & (avs_address == nvclock_pkg::AV_MASK);

   function automatic logic [7:0] bcd_inc(input logic [7:0] v);
      bcd_inc = (v[3:0] == 4'h9) ? {4'(v[7:4] + 4'h1), 4'h0} : 8'(v + 8'h01);
   endfunction

   function automatic logic bcd_mult4(input logic [7:0] v);
      bcd_mult4 = v[4] ? (v[3:0] == 4'h2 || v[3:0] == 4'h6)
                       : (v[3:0] == 4'h0 || v[3:0] == 4'h4 || v[3:0] == 4'h8);
   endfunction

   function automatic logic [7:0] month_days(input logic [7:0] m, input logic leap);
      case (m)
         8'h02:                      month_days = leap ? 8'h29 : 8'h28;
         8'h04, 8'h06, 8'h09, 8'h11: month_days = 8'h30;
         default:                    month_days = 8'h31;
      endcase
   endfunction

   wire         leap_year = (cnt_reg[nvclock_pkg::IDX_YEAR] == 8'h00) ?
                            bcd_mult4(cnt_reg[nvclock_pkg::IDX_CENT]) :
                            bcd_mult4(cnt_reg[nvclock_pkg::IDX_YEAR]);
   wire  [7:0]  last_date = month_days(cnt_reg[nvclock_pkg::IDX_MONTH], leap_year);
   wire         c_sec     = cnt_reg[nvclock_pkg::IDX_SEC] == nvclock_pkg::BCD_59;
   wire         c_min     = c_sec & (cnt_reg[nvclock_pkg::IDX_MIN] == nvclock_pkg::BCD_59);
   wire         c_hour    = c_min & (cnt_reg[nvclock_pkg::IDX_HOUR] == nvclock_pkg::BCD_23);
   wire         c_date    = c_hour & (cnt_reg[nvclock_pkg::IDX_DATE] == last_date);
   wire         c_month   = c_date & (cnt_reg[nvclock_pkg::IDX_MONTH] == nvclock_pkg::BCD_12);
   wire         c_year    = c_month & (cnt_reg[nvclock_pkg::IDX_YEAR] == nvclock_pkg::BCD_99);

   always_comb begin
      for (int i = 0; i < 8; i++) begin
         cnt_next[i] = cnt_reg[i];
      end
      if (load_time) begin
         for (int i = 1; i < 8; i++) begin
            cnt_next[i] = vis_reg[i];
         end
         cnt_next[nvclock_pkg::IDX_CENT] = {2'b00, data_lines_in[5:0]};
      end else if (run_tick) begin
         cnt_next[nvclock_pkg::IDX_SEC] = c_sec ? 8'h00 : bcd_inc(cnt_reg[nvclock_pkg::IDX_SEC]);
         if (c_sec) begin
            cnt_next[nvclock_pkg::IDX_MIN] = c_min ? 8'h00 : bcd_inc(cnt_reg[nvclock_pkg::IDX_MIN]);
         end
         if (c_min) begin
            cnt_next[nvclock_pkg::IDX_HOUR] = c_hour ? 8'h00 : bcd_inc(cnt_reg[nvclock_pkg::IDX_HOUR]);
         end
         if (c_hour) begin
            cnt_next[nvclock_pkg::IDX_DAY] = (cnt_reg[nvclock_pkg::IDX_DAY] == nvclock_pkg::BCD_07) ?
                                             nvclock_pkg::BCD_01 : bcd_inc(cnt_reg[nvclock_pkg::IDX_DAY]);
            cnt_next[nvclock_pkg::IDX_DATE] = c_date ? nvclock_pkg::BCD_01 :
                                              bcd_inc(cnt_reg[nvclock_pkg::IDX_DATE]);
         end
         if (c_date) begin
            cnt_next[nvclock_pkg::IDX_MONTH] = c_month ? nvclock_pkg::BCD_01 :
                                               bcd_inc(cnt_reg[nvclock_pkg::IDX_MONTH]);
         end
         if (c_month) begin
            cnt_next[nvclock_pkg::IDX_YEAR] = c_year ? 8'h00 : bcd_inc(cnt_reg[nvclock_pkg::IDX_YEAR]);
         end
         if (c_year) begin
            cnt_next[nvclock_pkg::IDX_CENT] = bcd_inc(cnt_reg[nvclock_pkg::IDX_CENT]);
         end
      end else if (cent_plain) begin
         cnt_next[nvclock_pkg::IDX_CENT] = {2'b00, data_lines_in[5:0]};
      end
   end

   always_ff @(posedge mclk) begin
      for (int i = 0; i < 8; i++) begin
         if (rst) begin
            cnt_reg[i] <= (i == 0) ? nvclock_pkg::RST_CENT : ((i == 4 || i >= 5) && i != 7) ?
                          nvclock_pkg::RST_ONE : 8'h00;
         end else begin
            cnt_reg[i] <= cnt_next[i];
         end
      end
   end

   always_ff @(posedge mclk) begin
      for (int i = 0; i < 8; i++) begin
         if (rst) begin
            vis_reg[i] <= 8'h00;
         end else if (clk_wr && idx == 3'(i) && i != 0) begin
            vis_reg[i] <= data_lines_in;
         end else if (i == 0 && (load_time || cent_plain)) begin
            vis_reg[i] <= {2'b00, data_lines_in[5:0]};
         end else if (!halted) begin
            vis_reg[i] <= cnt_reg[i];
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         w_bit_reg <= 1'b0;
         r_bit_reg <= 1'b0;
      end else if (ctrl_wr) begin
         w_bit_reg <= wr_w;
         r_bit_reg <= wr_r;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         crystal_halt_bit <= 1'b0;
         freq_test_bit    <= 1'b0;
      end else begin
         if (clk_wr && idx == nvclock_pkg::IDX_SEC) begin
            crystal_halt_bit <= data_lines_in[nvclock_pkg::SEC_OSC_BIT];
         end
         if (clk_wr && idx == nvclock_pkg::IDX_DAY) begin
            freq_test_bit <= data_lines_in[nvclock_pkg::DAY_FT_BIT];
         end
      end
   end

   // Loading a new time restarts the second so the first tick is a full second away.
   always_ff @(posedge mclk) begin
      if (rst || load_time || sec_tick) begin
         div_reg <= 25'h0000000;
      end else if (!crystal_halt_bit) begin
         div_reg <= div_reg + 25'h0000001;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst || ft_tick) begin
         ft_div_reg <= 16'h0000;
      end else if (!crystal_halt_bit) begin
         ft_div_reg <= ft_div_reg + 16'h0001;
      end
      if (rst || !freq_test_bit) begin
         ft_phase_reg <= 1'b0;
      end else if (ft_tick) begin
         ft_phase_reg <= ~ft_phase_reg;
      end
   end

   always_comb begin
      case (idx)
         nvclock_pkg::IDX_CENT: rd_mux = {w_bit_reg, r_bit_reg, vis_reg[0][5:0]};
         nvclock_pkg::IDX_SEC:  rd_mux = {crystal_halt_bit, vis_reg[1][6:1],
                                         freq_test_bit ? ft_phase_reg : vis_reg[1][0]};
         nvclock_pkg::IDX_DAY:  rd_mux = {battery_ok, freq_test_bit, 3'b000, vis_reg[4][2:0]};
         default:               rd_mux = vis_reg[idx];
      endcase
   end

   nv_mem_array u_mem (
      .mclk  (mclk),
      .wr_en (mem_wr),
      .addr  (address_pins),
      .wdata (data_lines_in),
      .rdata (mem_rdata)
   );

   always_ff @(posedge mclk) begin
      if (rst) begin
         oe_reg      <= 1'b0;
         sel_clk_reg <= 1'b0;
         clk_rd_reg  <= 8'h00;
      end else begin
         oe_reg      <= host_rd;
         sel_clk_reg <= clk_sel;
         clk_rd_reg  <= rd_mux;
      end
   end

   assign data_lines_out = sel_clk_reg ? clk_rd_reg : mem_rdata;
   assign data_lines_oe  = oe_reg;

   always_ff @(posedge mclk) begin
      if (rst) begin
         por_reg         <= 1'b0;
         supply_prev_reg <= 1'b0;
      end else begin
         por_reg         <= supply_ok;
         supply_prev_reg <= supply_ok;
      end
   end

   assign por_out_n = por_reg;

   // Sticky events; a new event wins over a clear in the same cycle.
   assign events[nvclock_pkg::EV_SEC]   = run_tick;
   assign events[nvclock_pkg::EV_PFAIL] = supply_prev_reg & ~supply_ok;
   assign events[nvclock_pkg::EV_LOAD]  = load_time;
   assign events[nvclock_pkg::EV_W]     = ctrl_wr & wr_w & ~w_bit_reg;

   always_ff @(posedge mclk) begin
      if (rst) begin
         status_reg <= 4'h0;
         mask_reg   <= 4'h0;
      end else begin
         status_reg <= (status_reg & ~(wr_status ? avs_writedata[3:0] : 4'h0)) | events;
         if (wr_mask) begin
            mask_reg <= avs_writedata[3:0];
         end
      end
   end

   assign irq = |(status_reg & mask_reg);

   // One wait state: the request is taken at the edge where waitrequest is low.
   always_ff @(posedge mclk) begin
      if (rst) begin
         ack_reg   <= 1'b0;
         rdata_reg <= 32'h00000000;
      end else begin
         ack_reg <= av_req & ~ack_reg;
         case (avs_address)
            nvclock_pkg::AV_STATUS: rdata_reg <= {28'h0000000, status_reg};
            nvclock_pkg::AV_MASK:   rdata_reg <= {28'h0000000, mask_reg};
            nvclock_pkg::AV_POWER:  rdata_reg <= {27'h0000000, crystal_halt_bit, r_bit_reg,
                                                  w_bit_reg, battery_ok, supply_ok};
            default:                rdata_reg <= 32'h00000000;
         endcase
      end
   end

   assign avs_waitrequest = av_req & ~ack_reg;
   assign avs_readdata    = rdata_reg;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   a_power_fail_quiet: assert property (!supply_ok |=> !data_lines_oe ##0 !por_out_n)
      else $error("Outputs active during supply fault.");
   a_por_follows: assert property ($rose(supply_ok) |=> por_out_n)
      else $error("Reset output not released after supply.");
   a_halt_freezes: assert property (halted && !clk_wr |=> $stable(vis_reg[1]))
      else $error("Visible seconds changed while halted.");
   a_count_runs: assert property (r_bit_reg && sec_tick && !load_time |=> cnt_reg[1] != $past(cnt_reg[1]))
      else $error("Count stopped during read halt.");
   a_load_time: assert property (load_time |=> cnt_reg[1] == $past(vis_reg[1])
                                 ##0 cnt_reg[0][5:0] == $past(data_lines_in[5:0]))
      else $error("Set time not transferred.");
   a_read_resume: assert property (ctrl_wr && r_bit_reg && !w_bit_reg && !wr_w && !wr_r && !(run_tick && c_year)
                                   |=> $stable(cnt_reg[0]))
      else $error("Century changed on read release.");
   a_osc_stop: assert property (crystal_halt_bit && !load_time && !cent_plain |=> $stable(cnt_reg[1]))
      else $error("Seconds advanced with oscillator stopped.");
   a_hour_wrap: assert property (run_tick && c_hour |=> cnt_reg[3] == 8'h00 ##0 cnt_reg[1] == 8'h00)
      else $error("Day rollover wrong.");
   a_feb_end: assert property (run_tick && c_hour && cnt_reg[6] == 8'h02 && cnt_reg[5] == 8'h28 && !leap_year
                               |=> cnt_reg[5] == 8'h01 ##0 cnt_reg[6] == 8'h03)
      else $error("February rollover wrong.");
   a_century_carry: assert property (run_tick && c_year |=> cnt_reg[7] == 8'h00
                                     ##0 cnt_reg[0] == bcd_inc($past(cnt_reg[0])))
      else $error("Century not carried.");
   a_battery_flag: assert property (host_rd && clk_sel && idx == 3'h4 |=> data_lines_out[7] == $past(battery_ok))
      else $error("Battery flag misreported.");
   a_ctrl_readback: assert property (host_rd && clk_sel && idx == 3'h0
                                     |=> data_lines_out[5:0] == $past(vis_reg[0][5:0]) ##0 data_lines_oe)
      else $error("Century readback wrong.");
   a_mem_select: assert property (host_rd && !clk_sel |=> data_lines_out == $past(u_mem.mem_reg[address_pins]))
      else $error("Memory read data wrong.");
   a_ft_toggle: assert property (freq_test_bit && ft_tick && $past(freq_test_bit) |=> ft_phase_reg != $past(ft_phase_reg))
      else $error("Test toggle missed.");
   a_status_sticky: assert property (status_reg[nvclock_pkg::EV_PFAIL] && !wr_status |=> status_reg[nvclock_pkg::EV_PFAIL])
      else $error("Status bit lost before clear.");

   c_load: cover property (ctrl_wr && wr_w ##[1:50] load_time);
   c_read_halt: cover property (r_bit_reg && sec_tick);
   c_pfail: cover property (events[1]);
   c_ft: cover property (freq_test_bit && ft_tick);
endmodule

/* File: nv_host_model.sv */
// Host processor model for the byte-wide memory port of the clock memory.
// Assumes the device samples its pins at the rising edge of mclk.
module nv_host_model (
   input  wire logic        mclk,
   output      logic [18:0] address_pins,
   output      logic [7:0]  data_lines_in,
   output      logic        chip_en_n,
   output      logic        out_en_n,
   output      logic        write_en_n,
   input  wire logic [7:0]  data_lines_out,
   input  wire logic        data_lines_oe
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      address_pins = 19'h00000;
      data_lines_in = 8'hFF;
      chip_en_n = 1'b1;
      out_en_n = 1'b1;
      write_en_n = 1'b1;
   end
   task automatic wr(input logic [18:0] a, input logic [7:0] d);
      @(posedge mclk);
      address_pins <= a;
      data_lines_in <= d;
      chip_en_n <= 1'b0;
      write_en_n <= 1'b0;
      @(posedge mclk);
      chip_en_n <= 1'b1;
      write_en_n <= 1'b1;
      // Released data is inverted so a stale byte never looks valid.
      data_lines_in <= ~d;
   endtask
   task automatic rd(input logic [18:0] a, input int n, output logic [8:0] q, output int tg);
      logic p;
      @(posedge mclk);
      address_pins <= a;
      chip_en_n <= 1'b0;
      out_en_n <= 1'b0;
      @(posedge mclk);
      @(negedge mclk);
      q = {data_lines_oe, data_lines_out};
      p = q[0];
      tg = 0;
      repeat (n) begin
         @(negedge mclk);
         if (data_lines_out[0] !== p) tg++;
         p = data_lines_out[0];
      end
      @(posedge mclk);
      chip_en_n <= 1'b1;
      out_en_n <= 1'b1;
   endtask
endmodule

/* File: test_nv_sram_calendar_clock.sv */
// Self-checking bench for the byte memory with calendar clock.
// Assumes nv_host_model on the memory port and a 25 MHz clock.
module test_nv_sram_calendar_clock;
   timeunit 1ns;
   timeprecision 1ns;
   // A short second keeps calendar rollovers within a brief run.
   localparam int SC = 50;
   logic        mclk, rst, chip_en_n, out_en_n, write_en_n, data_lines_oe;
   logic        supply_ok, battery_ok, por_out_n, avs_read, avs_write;
   logic        avs_waitrequest, irq;
   logic [18:0] address_pins;
   logic [7:0]  data_lines_in, data_lines_out;
   logic [1:0]  avs_address;
   logic [31:0] avs_writedata, avs_readdata, r;
   logic [8:0]  q;
   int          bad_count, checks_done, cyc, tg;
   nv_sram_calendar_clock #(.SEC_CYCLES(SC), .FT_HALF_CYCLES(5)) nv_sram_calendar_clock_i (
      .mclk(mclk), .rst(rst), .address_pins(address_pins), .data_lines_in(data_lines_in),
      .data_lines_out(data_lines_out), .data_lines_oe(data_lines_oe), .chip_en_n(chip_en_n),
      .out_en_n(out_en_n), .write_en_n(write_en_n), .supply_ok(supply_ok),
      .battery_ok(battery_ok), .por_out_n(por_out_n), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq));
   nv_host_model nv_host_model_i (
      .mclk(mclk), .address_pins(address_pins), .data_lines_in(data_lines_in),
      .chip_en_n(chip_en_n), .out_en_n(out_en_n), .write_en_n(write_en_n),
      .data_lines_out(data_lines_out), .data_lines_oe(data_lines_oe));
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   task automatic results;
      if (bad_count == 0 && checks_done > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   always @(posedge mclk) begin
      cyc = cyc + 1;
      if (cyc == 10000) begin
         bad_count++;
         results();
      end
   end
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic av(input logic w, input logic [1:0] a, input logic [31:0] d);
      @(posedge mclk);
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= ~w;
      avs_write <= w;
      do @(posedge mclk); while (avs_waitrequest !== 1'b0);
      r = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic hw(input logic [2:0] i, input logic [7:0] d);
      nv_host_model_i.wr({nvclock_pkg::CLK_PAGE, i}, d);
   endtask
   task automatic hr(input logic [2:0] i, input int n);
      nv_host_model_i.rd({nvclock_pkg::CLK_PAGE, i}, n, q, tg);
   endtask
   task automatic t_reset;
      hr(3'h0, 0);
      chk("century", 9'h120, q);
      hr(3'h4, 0);
      chk("day", 9'h181, q);
   endtask
   task automatic t_mem;
      nv_host_model_i.wr(19'h00000, 8'hA5);
      nv_host_model_i.wr(19'h7FFF7, 8'h3C);
      nv_host_model_i.rd(19'h00000, 0, q, tg);
      chk("mem low", 9'h1A5, q);
      nv_host_model_i.rd(19'h7FFF7, 0, q, tg);
      chk("mem top", 9'h13C, q);
   endtask
   // Loads Feb 28 23:59:59, lets one second pass, then reads under read halt.
   task automatic t_cal(input logic [7:0] c, input logic [7:0] y, input logic [7:0] m, input logic [7:0] d);
      hw(3'h0, 8'h80);
      hw(3'h7, y);
      hw(3'h6, 8'h02);
      hw(3'h5, 8'h28);
      hw(3'h4, 8'h03);
      hw(3'h3, 8'h23);
      hw(3'h2, 8'h59);
      hw(3'h1, 8'h59);
      hw(3'h0, c);
      repeat (SC + 10) @(posedge mclk);
      hw(3'h0, 8'h40);
      hr(3'h6, 0);
      chk("month", {1'b1, m}, q);
      hr(3'h5, 0);
      chk("date", {1'b1, d}, q);
      hr(3'h4, 0);
      chk("day", 9'h184, q);
      hr(3'h3, 0);
      chk("hour", 9'h100, q);
      hr(3'h2, 0);
      chk("minute", 9'h100, q);
      hr(3'h7, 0);
      chk("year", {1'b1, y}, q);
      hr(3'h0, 0);
      chk("control", {1'b1, 8'h40 | c}, q);
      av(1'b0, nvclock_pkg::AV_STATUS, 32'h0);
      chk("status", 32'hC, r & 32'hC);
      repeat (SC + 10) @(posedge mclk);
      hr(3'h1, 0);
      chk("frozen", 9'h100, q);
      hw(3'h0, 8'h00);
      hr(3'h0, 0);
      chk("century kept", {1'b1, c}, q);
      hr(3'h1, 0);
      chk("resumed", 32'h1, q[7:0] !== 8'h00);
   endtask
   // Loads the last second of a century and checks the carry into the next one.
   task automatic t_year;
      hw(3'h0, 8'h80);
      hw(3'h7, 8'h99);
      hw(3'h6, 8'h12);
      hw(3'h5, 8'h31);
      hw(3'h3, 8'h23);
      hw(3'h2, 8'h59);
      hw(3'h1, 8'h59);
      hw(3'h0, 8'h20);
      repeat (SC + 10) @(posedge mclk);
      hw(3'h0, 8'h40);
      hr(3'h7, 0);
      chk("year wrap", 9'h100, q);
      hr(3'h6, 0);
      chk("month wrap", 9'h101, q);
      hr(3'h0, 0);
      chk("century carry", 9'h161, q);
      hw(3'h0, 8'h00);
   endtask
   task automatic t_pfail;
      av(1'b1, nvclock_pkg::AV_MASK, 32'h2);
      @(posedge mclk);
      chk("irq idle", 1'b0, irq);
      supply_ok <= 1'b0;
      repeat (2) @(posedge mclk);
      chk("reset out", 1'b0, por_out_n);
      nv_host_model_i.wr(19'h00000, 8'h5A);
      nv_host_model_i.rd(19'h00000, 0, q, tg);
      chk("oe off", 1'b0, q[8]);
      supply_ok <= 1'b1;
      repeat (3) @(posedge mclk);
      chk("reset out", 1'b1, por_out_n);
      nv_host_model_i.rd(19'h00000, 0, q, tg);
      chk("mem kept", 9'h1A5, q);
      chk("irq", 1'b1, irq);
      av(1'b1, nvclock_pkg::AV_STATUS, 32'h2);
      @(posedge mclk);
      chk("irq clear", 1'b0, irq);
      av(1'b0, 2'h3, 32'h0);
      chk("unmapped", 32'h0, r);
      av(1'b0, nvclock_pkg::AV_MASK, 32'h0);
      chk("mask", 32'h2, r);
      av(1'b0, nvclock_pkg::AV_POWER, 32'h0);
      chk("power", 32'h3, r);
      battery_ok <= 1'b0;
      hr(3'h4, 0);
      chk("battery", 2'b10, q[8:7]);
      battery_ok <= 1'b1;
   endtask
   task automatic t_ft;
      hw(3'h4, 8'h44);
      hr(3'h1, 24);
      chk("toggles", 32'h1, tg >= 4);
      hw(3'h1, 8'h80);
      av(1'b0, nvclock_pkg::AV_POWER, 32'h0);
      chk("osc stop", 1'b1, r[4]);
      hr(3'h1, 24);
      chk("stopped", 32'h0, tg);
      chk("stop bit", 2'b11, q[8:7]);
      hw(3'h1, 8'h00);
      hr(3'h1, 24);
      chk("restart", 32'h1, tg >= 4);
   endtask
   initial begin
      rst = 1'b1;
      supply_ok = 1'b1;
      battery_ok = 1'b1;
      avs_address = 2'h0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      bad_count = 0;
      checks_done = 0;
      cyc = 0;
      repeat (3) @(posedge mclk);
      rst <= 1'b0;
      t_reset();
      t_mem();
      t_cal(8'h20, 8'h24, 8'h02, 8'h29);
      t_cal(8'h21, 8'h00, 8'h03, 8'h01);
      t_year();
      t_pfail();
      t_ft();
      results();
   end
endmodule
